// ---- rtl/dsk_pkg.sv ----
package dsk_pkg;

    localparam int DSK_ADDR_W = 14;
    localparam int DSK_DATA_W = 8;

    // Upper six bits of the instruction word for each operation.
    localparam logic [5:0] DSK_OP_SKIP_NONZERO = 6'h13;
    localparam logic [5:0] DSK_OP_SKIP_ZERO = 6'h0B;

    // Access Bank split point and the bank that holds its upper half.
    localparam logic [7:0] DSK_INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] DSK_ACCESS_SPLIT = 8'h60;
    localparam logic [5:0] DSK_ACCESS_HIGH_BANK = 6'h3F;
    localparam logic [5:0] DSK_ACCESS_LOW_BANK = 6'h00;

    // Q phase numbering within one instruction cycle.
    localparam logic [1:0] DSK_Q1 = 2'h0;
    localparam logic [1:0] DSK_Q2 = 2'h1;
    localparam logic [1:0] DSK_Q3 = 2'h2;
    localparam logic [1:0] DSK_Q4 = 2'h3;

    localparam logic [1:0] DSK_PHASE_RESET = 2'h0;
    localparam logic [1:0] DSK_ONE_WORD = 2'h1;
    localparam logic [1:0] DSK_NO_WORDS = 2'h0;
    localparam logic [7:0] DSK_DATA_ONE = 8'h01;
    localparam logic [7:0] DSK_DATA_ZERO = 8'h00;
    localparam logic [13:0] DSK_ADDR_ZERO = 14'h0000;

    typedef struct packed {
        logic [5:0] opcode;
        logic dest_file;
        logic access_banked;
        logic [7:0] file_addr;
    } dsk_instr_type;

    typedef struct packed {
        logic [DSK_ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DSK_DATA_W-1:0] wdata;
    } dsk_file_port_type;

    typedef enum logic [1:0] {
        DSK_ST_IDLE,
        DSK_ST_EXEC,
        DSK_ST_SKIP
    } dsk_state_type;

endpackage : dsk_pkg

// ---- rtl/dsk_core.sv ----
`timescale 1ns/1ns

// What this block does
// - Decode word 0100_11da_ffff_ffff as decrement and skip if nonzero.
// - Subtract one from file register; destination bit picks working register or file.
// - Nonzero result discards the fetched next instruction, running a no-operation cycle.
// - Access bit zero uses Access Bank; one uses bank select register.
// - Access zero with extended set uses indexed literal offset for addresses up to 95.
// - One program word; one cycle without skip, plus one cycle per word of the skipped instruction with skip.
// - Executing cycle decodes Q1, reads Q2, processes Q3, writes Q4.
// - Each skipped instruction word costs one full no-operation cycle.
// - Decrement and skip if zero skips on zero and proceeds on nonzero.
module dsk_core
    import dsk_pkg::*;
(
    input wire logic CLK_IN,                          // Core clock, four per instruction cycle
    input wire logic SYS_RST_IN,                      // Synchronous reset, active high
    input wire logic INSTR_VALID_IN,                  // Instruction word is present at Q1
    input wire logic [15:0] INSTR_IN,                 // Fetched instruction word
    input wire logic [1:0] NEXT_WORDS_IN,             // Word count of the already-fetched next instruction
    input wire logic [5:0] BANK_SELECT_IN,            // Bank select register value
    input wire logic EXT_SET_EN_IN,                   // Extended instruction set enabled
    input wire logic [13:0] INDEX_BASE_IN,            // Pointer base for indexed literal offset mode
    input wire logic [7:0] FILE_RDATA_IN,             // File register read data, valid during Q2
    output dsk_file_port_type FILE_PORT_OUT,          // File register address, strobes and write data
    output logic WREG_WR_OUT,                         // Working register write strobe in Q4
    output logic [7:0] WREG_WDATA_OUT,                // Working register write data
    output logic [1:0] PHASE_OUT,                     // Current Q phase
    output logic BUSY_OUT,                            // Block owns the current instruction cycle
    output logic NOP_CYCLE_OUT                        // A discarded word is being replaced by no-operation
);

    dsk_state_type state_q;
    logic [1:0] phase_q;
    dsk_instr_type instr_q;
    logic [7:0] result_q;
    logic [1:0] skip_left_q;
    dsk_instr_type instr_in;
    logic take_in;
    logic result_zero;
    logic do_skip;
    logic [13:0] addr_d;
    logic exec_write;
    logic exec_end;
    logic skip_start;
    logic skip_end;

    assign instr_in = dsk_instr_type'(INSTR_IN);

    assign take_in = (state_q == DSK_ST_IDLE) && (phase_q == DSK_Q1) && INSTR_VALID_IN
        && ((instr_in.opcode == DSK_OP_SKIP_NONZERO) || (instr_in.opcode == DSK_OP_SKIP_ZERO));

    assign result_zero = (result_q == DSK_DATA_ZERO);

    assign do_skip = (instr_q.opcode == DSK_OP_SKIP_NONZERO) ? !result_zero : result_zero;

    // Strobes are registered, so they are armed in the phase before the one that they mark.
    // write in Q4
    assign exec_write = (state_q == DSK_ST_EXEC) && (phase_q == DSK_Q3);

    assign exec_end = (state_q == DSK_ST_EXEC) && (phase_q == DSK_Q4);

    // The word count of the fetched next instruction is only looked at here, at the last edge of Q4.
    // skip cycles follow
    assign skip_start = exec_end && do_skip && (NEXT_WORDS_IN != DSK_NO_WORDS);

    assign skip_end = (state_q == DSK_ST_SKIP) && (phase_q == DSK_Q4) && (skip_left_q == DSK_ONE_WORD);

    always_comb begin
        if (instr_in.access_banked) begin
            addr_d = {BANK_SELECT_IN, instr_in.file_addr};
        end else if (EXT_SET_EN_IN && (instr_in.file_addr <= DSK_INDEXED_LIMIT)) begin
            addr_d = 14'(INDEX_BASE_IN + {6'h00, instr_in.file_addr});
        end else if (instr_in.file_addr < DSK_ACCESS_SPLIT) begin
            addr_d = {DSK_ACCESS_LOW_BANK, instr_in.file_addr};
        end else begin
            addr_d = {DSK_ACCESS_HIGH_BANK, instr_in.file_addr};
        end
    end

    // The phase runs freely, so an instruction is only taken in a Q1 clock.
    // free-running Q phase
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            phase_q <= DSK_PHASE_RESET;
        end else begin
            phase_q <= phase_q + DSK_ONE_WORD;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state_q <= DSK_ST_IDLE;
        end else begin
            unique case (state_q)
                DSK_ST_IDLE: begin
                    if (take_in) begin
                        state_q <= DSK_ST_EXEC;
                    end
                end
                DSK_ST_EXEC: begin
                    if (skip_start) begin
                        state_q <= DSK_ST_SKIP;
                    end else if (exec_end) begin
                        state_q <= DSK_ST_IDLE;
                    end
                end
                DSK_ST_SKIP: begin
                    if (skip_end) begin
                        state_q <= DSK_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            skip_left_q <= DSK_NO_WORDS;
        end else if (skip_start) begin
            skip_left_q <= NEXT_WORDS_IN;
        end else if ((state_q == DSK_ST_SKIP) && (phase_q == DSK_Q4)) begin
            skip_left_q <= skip_left_q - DSK_ONE_WORD;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            instr_q <= '0;
        end else if (take_in) begin
            instr_q <= instr_in;
        end
    end

    // decrement captured at end of Q2
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            result_q <= DSK_DATA_ZERO;
        end else if ((state_q == DSK_ST_EXEC) && (phase_q == DSK_Q2)) begin
            result_q <= FILE_RDATA_IN - DSK_DATA_ONE;
        end
    end

    // read in Q2, write in Q4
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            FILE_PORT_OUT <= '{addr: DSK_ADDR_ZERO, rd: 1'b0, wr: 1'b0, wdata: DSK_DATA_ZERO};
        end else begin
            FILE_PORT_OUT.rd <= take_in;
            if (take_in) begin
                FILE_PORT_OUT.addr <= addr_d;
            end
            FILE_PORT_OUT.wr <= exec_write && instr_q.dest_file;
            if (exec_write) begin
                FILE_PORT_OUT.wdata <= result_q;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            WREG_WR_OUT <= 1'b0;
            WREG_WDATA_OUT <= DSK_DATA_ZERO;
        end else begin
            WREG_WR_OUT <= exec_write && !instr_q.dest_file;
            if (exec_write) begin
                WREG_WDATA_OUT <= result_q;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            PHASE_OUT <= DSK_PHASE_RESET;
        end else begin
            PHASE_OUT <= phase_q + DSK_ONE_WORD;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            BUSY_OUT <= 1'b0;
        end else if (take_in) begin
            BUSY_OUT <= 1'b1;
        end else if (exec_end) begin
            BUSY_OUT <= skip_start;
        end else if (skip_end) begin
            BUSY_OUT <= 1'b0;
        end
    end

    // no-operation in place of next word
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            NOP_CYCLE_OUT <= 1'b0;
        end else if (exec_end) begin
            NOP_CYCLE_OUT <= skip_start;
        end else if (skip_end) begin
            NOP_CYCLE_OUT <= 1'b0;
        end
    end

endmodule : dsk_core

// ---- tb/dsk_core_props.sv ----
`timescale 1ns/1ns
module dsk_core_props
    import dsk_pkg::*;
(
    input wire logic CLK_IN, // Core clock
    input wire logic SYS_RST_IN, // Reset
    input wire logic [7:0] FILE_RDATA_IN, // Read data
    input dsk_file_port_type FILE_PORT_OUT, // File port
    input wire logic WREG_WR_OUT, // W strobe
    input wire logic [7:0] WREG_WDATA_OUT, // W data
    input wire logic [1:0] PHASE_OUT, // Phase
    input wire logic BUSY_OUT, // Busy
    input wire logic NOP_CYCLE_OUT // Nop cycle
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence s_write;
        FILE_PORT_OUT.wr || WREG_WR_OUT;
    endsequence
    sequence s_nop_cycle;
        PHASE_OUT == DSK_Q1 ##0 NOP_CYCLE_OUT [*4];
    endsequence
    chk_read_then_write: assert property (FILE_PORT_OUT.rd |-> ##2 s_write)
        else $error("write not two clocks after read");
    chk_read_phase: assert property (FILE_PORT_OUT.rd |-> PHASE_OUT == DSK_Q2)
        else $error("read outside Q2");
    chk_write_phase: assert property (s_write |-> PHASE_OUT == DSK_Q4)
        else $error("write outside Q4");
    chk_one_dest: assert property (!(FILE_PORT_OUT.wr && WREG_WR_OUT))
        else $error("both destinations written");
    chk_dec_value: assert property (s_write |-> (FILE_PORT_OUT.wr ? FILE_PORT_OUT.wdata : WREG_WDATA_OUT)
        == $past(FILE_RDATA_IN, 2) - DSK_DATA_ONE) else $error("result is not operand minus one");
    chk_phase_wrap: assert property (PHASE_OUT == DSK_Q4 |=> PHASE_OUT == DSK_Q1)
        else $error("phase did not wrap");
    chk_nop_whole: assert property ($rose(NOP_CYCLE_OUT) |-> s_nop_cycle)
        else $error("partial no-operation cycle");
    chk_nop_busy: assert property (NOP_CYCLE_OUT |-> BUSY_OUT)
        else $error("no-operation cycle while idle");
    chk_nop_end: assert property ($fell(NOP_CYCLE_OUT) |-> PHASE_OUT == DSK_Q1)
        else $error("no-operation cycle ended inside a cycle");
    chk_busy_end: assert property ($fell(BUSY_OUT) |-> PHASE_OUT == DSK_Q1)
        else $error("busy ended inside a cycle");
endmodule : dsk_core_props
bind dsk_core dsk_core_props u_props (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .FILE_RDATA_IN(FILE_RDATA_IN),
    .FILE_PORT_OUT(FILE_PORT_OUT), .WREG_WR_OUT(WREG_WR_OUT), .WREG_WDATA_OUT(WREG_WDATA_OUT),
    .PHASE_OUT(PHASE_OUT), .BUSY_OUT(BUSY_OUT), .NOP_CYCLE_OUT(NOP_CYCLE_OUT));

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
    import dsk_pkg::*;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, instr_valid_in = 1'b0, ext_set_en_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [1:0] next_words_in = 2'h0;
    logic [5:0] bank_select_in = 6'h00;
    logic [13:0] index_base_in = 14'h0000;
    logic [7:0] file_rdata_in = 8'h00;
    dsk_file_port_type file_port_out;
    logic wreg_wr_out, busy_out, nop_cycle_out;
    logic [7:0] wreg_wdata_out;
    logic [1:0] phase_out;
    int n_fail = 0;
    int samples_checked = 0;
    always #50 clk_in = ~clk_in;
    dsk_core dut (.CLK_IN(clk_in), .SYS_RST_IN(sys_rst_in), .INSTR_VALID_IN(instr_valid_in), .INSTR_IN(instr_in),
        .NEXT_WORDS_IN(next_words_in), .BANK_SELECT_IN(bank_select_in), .EXT_SET_EN_IN(ext_set_en_in),
        .INDEX_BASE_IN(index_base_in), .FILE_RDATA_IN(file_rdata_in), .FILE_PORT_OUT(file_port_out),
        .WREG_WR_OUT(wreg_wr_out), .WREG_WDATA_OUT(wreg_wdata_out), .PHASE_OUT(phase_out),
        .BUSY_OUT(busy_out), .NOP_CYCLE_OUT(nop_cycle_out));
    int exp_res_q[$];
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_addr(input logic [13:0] got, input logic [13:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_addr
    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_count(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_count
    task automatic tick;
        @(posedge clk_in);
        #10;
    endtask : tick
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic run(input logic [5:0] op, input int n);
        int res, skip, cnt, nops, match;
        logic [15:0] w;
        logic [13:0] ad;
        w = {op, 10'($urandom)};
        if ($urandom_range(3) == 0) begin
            w[7:0] = ($urandom_range(1) == 0) ? DSK_INDEXED_LIMIT : DSK_ACCESS_SPLIT;
        end
        file_rdata_in = ($urandom_range(2) == 0) ? 8'($urandom_range(1)) : 8'($urandom);
        next_words_in = 2'($urandom_range(3, 0));
        bank_select_in = 6'($urandom);
        ext_set_en_in = 1'($urandom);
        index_base_in = 14'($urandom);
        cnt = 0;
        while (!(phase_out === DSK_Q1 && busy_out === 1'b0) && cnt < 20) begin
            tick;
            cnt++;
        end
        instr_in = w;
        instr_valid_in = 1'b1;
        match = (op == DSK_OP_SKIP_NONZERO || op == DSK_OP_SKIP_ZERO);
        if (w[8]) begin
            ad = {bank_select_in, w[7:0]};
        end else if (ext_set_en_in && w[7:0] <= DSK_INDEXED_LIMIT) begin
            ad = index_base_in + 14'(w[7:0]);
        end else begin
            ad = {(w[7:0] >= DSK_ACCESS_SPLIT) ? DSK_ACCESS_HIGH_BANK : DSK_ACCESS_LOW_BANK, w[7:0]};
        end
        res = (int'(file_rdata_in) + 255) % 256;
        skip = (match && ((res != 0) == (op == DSK_OP_SKIP_NONZERO))) ? int'(next_words_in) : 0;
        if (match) begin
            exp_res_q.push_back(res);
        end
        tick;
        instr_valid_in = 1'b0;
        chk_bit(file_port_out.rd, 1'(match));
        if (match) chk_addr(file_port_out.addr, ad);
        tick;
        tick;
        chk_bit(file_port_out.wr, 1'(match && w[9]));
        chk_bit(wreg_wr_out, 1'(match && !w[9]));
        if (match) begin
            chk_data(w[9] ? file_port_out.wdata : wreg_wdata_out, 8'(exp_res_q.pop_front()));
        end
        cnt = 0;
        nops = 0;
        tick;
        while (busy_out === 1'b1 && cnt < 20) begin
            cnt++;
            nops += int'(nop_cycle_out);
            tick;
        end
        chk_count(16'(cnt), 16'(4 * skip));
        chk_count(16'(nops), 16'(4 * skip));
        $display("test %0d done", n);
    endtask : run
    initial begin
        void'($urandom(32'h02E20452));
        repeat (4) tick;
        sys_rst_in = 1'b0;
        for (int i = 0; i < 90; i++) begin
            run((i % 3 == 2) ? 6'($urandom) : ((i % 3 == 1) ? DSK_OP_SKIP_ZERO : DSK_OP_SKIP_NONZERO), i);
        end
        report_and_stop;
    end
    initial begin
        #1000000;
        n_fail++;
        report_and_stop;
    end
endmodule : tb
